//--- design/piel_top.sv
// Purpose: Power input event logic: lines 7..2 of eight power lines raise NMI and keyboard attention
// Assumes: One I/O access per cycle; rd/wr strobes are one-cycle pulses on ref_clk_i
// Notes:   Reads answer one cycle after the strobe on rdata_o
// Contract
// [RULE1] Interrupt enables for inputs 7..2 let changes on those inputs raise NMI.
// [RULE2] Input 7 raises NMI only on its rising edge.
// [RULE3] Attention enables for inputs 7..2 let those inputs assert keyboard attention.
// [RULE4] Enable register bits 9, 8, 1, 0 ignore writes and read zero.
// [RULE5] A set attention-arm bit makes its input's transitions assert keyboard attention.
// [RULE6] Qualifying transition on 2..6 or rising edge on 7 sets flag and NMI.
// [RULE7] Writing an input's enables to zero clears its event flag.
// [RULE8] With both enables set, the flag stays until both are cleared.
// [RULE9] An input's readable bit freezes at event and releases when flag clears.
// [RULE10] Input register low byte shows the states of all eight lines.
// [RULE11] Flag register bits 15..8 and 1..0 read zero; writes there ignored.
// [RULE12] Attention-arm bits sit at input register bits 13..8, independent of enables.
// [RULE13] Writing one to a flag position never sets that flag.
// [RULE14] Local-select bit steers input 2 to local access request or user use.
// [RULE15] Reset clears all interrupt enables, attention enables and event flags.
`timescale 1ns/1ps
module piel_top
	import piel_pkg::*;
(
	input  wire logic         ref_clk_i,            // System clock, 100 MHz
	input  wire logic         rstn_i,               // Asynchronous reset, active low
	input  wire piel_io_req_t io_req_i,             // I/O port request
	input  wire logic [7:0]   power_line_i,         // Power input pins, asynchronous
	output logic      [15:0]  rdata_o,              // Read data, valid cycle after rd
	output logic              nmi_o,                // Non-maskable interrupt, high active
	output logic              keyboard_attention_o, // Attention to keyboard controller
	output logic              local_access_request_o, // Input 2 as local access request
	output logic              update_enable_o       // Output-latch update enable bit
);

	logic [7:0] line_meta_reg;
	logic [7:0] line_sync_reg;
	logic [7:0] line_prev_reg;
	logic [5:0] nmi_enable_bits_reg;
	logic [5:0] attention_enable_bits_reg;
	logic [5:0] attention_arm_bits_reg;
	logic [5:0] event_flag_bits_reg;
	logic [5:0] event_flag_bits_next;
	logic [7:0] power_line_state_bits_reg;
	logic       local_request_select_reg;
	logic       update_enable_reg;
	logic [5:0] change;
	logic [5:0] nmi_hit;
	logic [5:0] atn_hit;
	logic [5:0] event_set;
	logic [5:0] en_nmi_wr;
	logic [5:0] en_atn_wr;
	logic       wr_enable;
	logic       wr_input;
	logic [15:0] rdata_next;
	logic [5:0] flag_keep;

	function automatic logic addr_hit(input piel_io_req_t r, input logic [15:0] a);
		return r.addr == a;
	endfunction

	// Two flops before any logic looks at the pins
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			line_meta_reg <= 8'h00;
			line_sync_reg <= 8'h00;
			line_prev_reg <= 8'h00;
		end else begin
			line_meta_reg <= power_line_i;
			line_sync_reg <= line_meta_reg;
			line_prev_reg <= line_sync_reg;
		end
	end

	assign wr_enable = io_req_i.wr && addr_hit(io_req_i, PIEL_ENABLE_ADDR);
	assign wr_input  = io_req_i.wr && addr_hit(io_req_i, PIEL_INPUT_ADDR);
	assign en_nmi_wr = io_req_i.wdata[PIEL_NMI_EN_LSB +: 6];
	assign en_atn_wr = io_req_i.wdata[PIEL_ATN_EN_LSB +: 6];

	// Inputs 2..6 act on any change, input 7 only on its rising edge
	always_comb begin
		change = line_sync_reg[7:2] ^ line_prev_reg[7:2];
		change[5] = line_sync_reg[7] & ~line_prev_reg[7]; // [RULE2]
	end

	assign nmi_hit   = change & nmi_enable_bits_reg;                  // [RULE1]
	assign atn_hit   = change &
		(attention_enable_bits_reg | attention_arm_bits_reg);           // [RULE3] [RULE5]
	assign event_set = nmi_hit | atn_hit;                               // [RULE6]

	// Enables and control bits; reserved enable positions are never stored
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			nmi_enable_bits_reg       <= PIEL_EN_RESET; // [RULE15]
			attention_enable_bits_reg <= PIEL_EN_RESET; // [RULE15]
		end else if (wr_enable) begin
			nmi_enable_bits_reg       <= en_nmi_wr;      // [RULE4]
			attention_enable_bits_reg <= en_atn_wr;      // [RULE4]
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			attention_arm_bits_reg   <= 6'h00;
			local_request_select_reg <= 1'b0;
			update_enable_reg        <= 1'b0;
		end else if (wr_input) begin
			attention_arm_bits_reg   <= io_req_i.wdata[PIEL_ARM_LSB +: 6]; // [RULE12]
			local_request_select_reg <= io_req_i.wdata[PIEL_LCL_SEL_BIT];
			update_enable_reg        <= io_req_i.wdata[PIEL_UPD_BIT];
		end
	end

	// A flag clears on an enable write that leaves both enables for its input zero; set beats clear
	always_comb begin
		event_flag_bits_next = event_flag_bits_reg;
		if (wr_enable) begin
			event_flag_bits_next = event_flag_bits_reg & (en_nmi_wr | en_atn_wr); // [RULE7] [RULE8]
		end
		event_flag_bits_next = event_flag_bits_next | event_set; // [RULE13]
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			event_flag_bits_reg <= PIEL_FLAG_RESET; // [RULE15]
		end else begin
			event_flag_bits_reg <= event_flag_bits_next;
		end
	end

	// Lines 1..0 never lock; 7..2 sample on their event and hold while their flag is set
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			power_line_state_bits_reg <= 8'h00;
		end else begin
			power_line_state_bits_reg[1:0] <= line_sync_reg[1:0]; // [RULE10]
			for (int i = 0; i < PIEL_EV_CNT; i++) begin
				if (event_set[i]) begin
					power_line_state_bits_reg[i+2] <= line_sync_reg[i+2]; // [RULE9]
				end else if (!event_flag_bits_reg[i]) begin
					power_line_state_bits_reg[i+2] <= line_sync_reg[i+2]; // [RULE10]
				end
			end
		end
	end

	always_comb begin
		rdata_next = PIEL_RD_IDLE;
		if (addr_hit(io_req_i, PIEL_INPUT_ADDR)) begin
			rdata_next = {update_enable_reg, local_request_select_reg,
				attention_arm_bits_reg, power_line_state_bits_reg};
		end else if (addr_hit(io_req_i, PIEL_FLAG_ADDR)) begin
			rdata_next = {8'h00, event_flag_bits_reg, 2'b00}; // [RULE11]
		end else if (addr_hit(io_req_i, PIEL_ENABLE_ADDR)) begin
			rdata_next = {nmi_enable_bits_reg, 2'b00, attention_enable_bits_reg, 2'b00};
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= PIEL_RD_IDLE;
		end else if (io_req_i.rd) begin
			rdata_o <= rdata_next;
		end
	end

	// Outputs are registered pulses/levels one cycle after the detected change
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			nmi_o                  <= 1'b0;
			keyboard_attention_o   <= 1'b0;
			local_access_request_o <= 1'b0;
			update_enable_o        <= 1'b0;
		end else begin
			nmi_o                  <= |nmi_hit;                                   // [RULE6]
			keyboard_attention_o   <= |atn_hit;                                   // [RULE3]
			local_access_request_o <= local_request_select_reg & line_sync_reg[2]; // [RULE14]
			update_enable_o        <= update_enable_reg;
		end
	end

	property p_nmi_rise7;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(line_sync_reg[7] && !line_prev_reg[7] && nmi_enable_bits_reg[5]) |=> nmi_o;
	endproperty
	a_nmi_rise7: assert property (p_nmi_rise7) else $error("input 7 rise lost NMI"); // [RULE2]

	property p_no_fall7;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(!line_sync_reg[7] && line_prev_reg[7] && ($past(line_sync_reg) ==
			line_prev_reg) && line_sync_reg[6:2] == line_prev_reg[6:2]) |=> !nmi_o;
	endproperty
	a_no_fall7: assert property (p_no_fall7) else $error("NMI on input 7 fall"); // [RULE2]

	property p_nmi_needs_en;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(nmi_enable_bits_reg == 6'h00) |=> !nmi_o;
	endproperty
	a_nmi_needs_en: assert property (p_nmi_needs_en) else $error("NMI without enable"); // [RULE1]

	property p_flag_sets;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(nmi_o || keyboard_attention_o) |-> (event_flag_bits_reg != 6'h00);
	endproperty
	a_flag_sets: assert property (p_flag_sets) else $error("event without flag"); // [RULE6]

	property p_flag_clear;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(wr_enable && io_req_i.wdata == 16'h0000 && event_set == 6'h00)
			|=> event_flag_bits_reg == 6'h00;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // [RULE7]

	// Flags whose two enables are not both written to zero this cycle must survive
	assign flag_keep = event_flag_bits_reg & ~({6{wr_enable}} & ~en_nmi_wr & ~en_atn_wr);

	property p_flag_hold;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(flag_keep != 6'h00) |=> ((event_flag_bits_reg & $past(flag_keep)) == $past(flag_keep));
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped early"); // [RULE8]

	property p_no_sw_set;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(event_set == 6'h00) |=> (event_flag_bits_reg & ~$past(event_flag_bits_reg)) == 6'h00;
	endproperty
	a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without event"); // [RULE13]

	property p_lock7;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(event_flag_bits_reg[5] && event_set[5] == 1'b0) |=>
			power_line_state_bits_reg[7] == $past(power_line_state_bits_reg[7]);
	endproperty
	a_lock7: assert property (p_lock7) else $error("locked input bit moved"); // [RULE9]

	property p_reset_clear;
		@(posedge ref_clk_i)
		!rstn_i |-> (nmi_enable_bits_reg == 6'h00 && event_flag_bits_reg == 6'h00);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left state"); // [RULE15]

	property p_nmi_change;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(((line_sync_reg[6:2] ^ line_prev_reg[6:2]) & nmi_enable_bits_reg[4:0]) != 5'h00)
			|=> nmi_o;
	endproperty
	a_nmi_change: assert property (p_nmi_change) else $error("input change lost NMI"); // [RULE1]

	property p_flag_on_rise7;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(line_sync_reg[7] && !line_prev_reg[7] && nmi_enable_bits_reg[5])
			|=> event_flag_bits_reg[5];
	endproperty
	a_flag_on_rise7: assert property (p_flag_on_rise7) else $error("no flag 7"); // [RULE6]

	property p_atn_needs_en;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		((attention_enable_bits_reg | attention_arm_bits_reg) == 6'h00)
			|=> !keyboard_attention_o;
	endproperty
	a_atn_needs_en: assert property (p_atn_needs_en) else $error("stray attention"); // [RULE3]

	property p_atn_rise7;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(line_sync_reg[7] && !line_prev_reg[7] && attention_enable_bits_reg[5])
			|=> keyboard_attention_o;
	endproperty
	a_atn_rise7: assert property (p_atn_rise7) else $error("input 7 lost attention"); // [RULE3]

	property p_atn_armed;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(((line_sync_reg[6:2] ^ line_prev_reg[6:2]) & attention_arm_bits_reg[4:0]) != 5'h00)
			|=> keyboard_attention_o;
	endproperty
	a_atn_armed: assert property (p_atn_armed) else $error("arm lost attention"); // [RULE5]

	property p_enable_rd_zero;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(io_req_i.rd && io_req_i.addr == PIEL_ENABLE_ADDR)
			|=> (rdata_o[9:8] == 2'b00 && rdata_o[1:0] == 2'b00);
	endproperty
	a_enable_rd_zero: assert property (p_enable_rd_zero) else $error("enable pad bits"); // [RULE4]

	property p_flag_rd_zero;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(io_req_i.rd && io_req_i.addr == PIEL_FLAG_ADDR)
			|=> (rdata_o[15:8] == 8'h00 && rdata_o[1:0] == 2'b00);
	endproperty
	a_flag_rd_zero: assert property (p_flag_rd_zero) else $error("flag pad bits"); // [RULE11]

	property p_low_live;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		1'b1 |=> power_line_state_bits_reg[1:0] == $past(line_sync_reg[1:0]);
	endproperty
	a_low_live: assert property (p_low_live) else $error("line 1..0 not live"); // [RULE10]

	property p_lcl_off;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		!local_request_select_reg |=> !local_access_request_o;
	endproperty
	a_lcl_off: assert property (p_lcl_off) else $error("local request while user"); // [RULE14]

	property p_lcl_on;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(local_request_select_reg && line_sync_reg[2]) |=> local_access_request_o;
	endproperty
	a_lcl_on: assert property (p_lcl_on) else $error("local request lost"); // [RULE14]

	property p_arm_write;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		wr_input |=> attention_arm_bits_reg == $past(io_req_i.wdata[PIEL_ARM_LSB +: 6]);
	endproperty
	a_arm_write: assert property (p_arm_write) else $error("arm bits not stored"); // [RULE12]

	property p_flag_wr_ignored;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(io_req_i.wr && io_req_i.addr == PIEL_FLAG_ADDR && event_set == 6'h00)
			|=> $stable(event_flag_bits_reg);
	endproperty
	a_flag_wr_ignored: assert property (p_flag_wr_ignored) else $error("flag written"); // [RULE13]

endmodule // piel_top

//--- design/piel_pkg.sv
// Purpose: Shared constants and types for the power input event logic
// Assumes: 16-bit I/O port access, 100 MHz system clock
// Notes:   Port addresses are the device's I/O addresses
package piel_pkg;

	localparam logic [15:0] PIEL_INPUT_ADDR  = 16'h8872;
	localparam logic [15:0] PIEL_FLAG_ADDR   = 16'h9072;
	localparam logic [15:0] PIEL_ENABLE_ADDR = 16'hC872;

	localparam int PIEL_NMI_EN_LSB  = 10;
	localparam int PIEL_ATN_EN_LSB  = 2;
	localparam int PIEL_FLAG_LSB    = 2;
	localparam int PIEL_ARM_LSB     = 8;
	localparam int PIEL_LCL_SEL_BIT = 14;
	localparam int PIEL_UPD_BIT     = 15;
	localparam int PIEL_EV_CNT      = 6;

	localparam logic [5:0]  PIEL_EN_RESET   = 6'h00;
	localparam logic [5:0]  PIEL_FLAG_RESET = 6'h00;
	localparam logic [15:0] PIEL_RD_IDLE    = 16'h0000;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} piel_io_req_t;

endpackage : piel_pkg

//--- dv/piel_host_model.sv
// Purpose: Host NMI input and keyboard controller stand-in
// Assumes: Both event outputs are one-cycle pulses
// Notes:   Counts high cycles so a stretched pulse shows as an extra event
`timescale 1ns/1ps
module piel_host_model (
	input  wire logic       ref_clk_i, // System clock
	input  wire logic       rstn_i,    // Reset, active low
	input  wire logic       nmi_i,     // NMI from the block
	input  wire logic       atn_i,     // Keyboard attention
	output logic      [7:0] nmi_cnt_o, // NMI cycles seen
	output logic      [7:0] atn_cnt_o  // Attention cycles seen
);
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			nmi_cnt_o <= 8'h00;
			atn_cnt_o <= 8'h00;
		end else begin
			nmi_cnt_o <= nmi_cnt_o + {7'h00, nmi_i};
			atn_cnt_o <= atn_cnt_o + {7'h00, atn_i};
		end
	end
endmodule // piel_host_model

//--- dv/piel_top_tb.sv
// Purpose: Self-checking bench for the power input event logic
// Assumes: Inputs change on the falling edge
// Notes:   Event totals come from the host model counters
`timescale 1ns/1ps
module piel_top_tb
	import piel_pkg::*;
;
	logic         ref_clk_i = 1'b0;
	logic         rstn_i;
	piel_io_req_t req;
	logic [7:0]   line;
	logic [15:0]  rdata;
	logic         nmi;
	logic         keyboard_attention;
	logic         lcl;
	logic         upd;
	logic [7:0]   nmi_cnt;
	logic [7:0]   atn_cnt;
	int           err_total = 0;
	int           checks = 0;

	always #5 ref_clk_i = ~ref_clk_i;

	piel_top dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .io_req_i(req),
		.power_line_i(line), .rdata_o(rdata), .nmi_o(nmi), .keyboard_attention_o(keyboard_attention),
		.local_access_request_o(lcl), .update_enable_o(upd));
	piel_host_model host_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .nmi_i(nmi),
		.atn_i(keyboard_attention), .nmi_cnt_o(nmi_cnt), .atn_cnt_o(atn_cnt));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge ref_clk_i);
		req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge ref_clk_i);
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
		@(negedge ref_clk_i);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge ref_clk_i);
		req.rd = 1'b0;
		chk(rdata, exp, what);
	endtask

	// Sync plus detect takes three edges; six leaves margin
	task automatic pin(input logic [7:0] v);
		@(negedge ref_clk_i);
		line = v;
		repeat (6) @(negedge ref_clk_i);
	endtask

	task automatic conclude;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge ref_clk_i);
		err_total++;
		conclude();
	end

	initial begin
		req = '0;
		line = 8'h00;
		rstn_i = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rstn_i = 1'b1;
		rd(PIEL_ENABLE_ADDR, 16'h0000, "enable reset");
		rd(PIEL_FLAG_ADDR, 16'h0000, "flag reset");
		rd(16'h8870, 16'h0000, "unmapped");
		wr(PIEL_ENABLE_ADDR, 16'hFFFF);
		rd(PIEL_ENABLE_ADDR, 16'hFCFC, "enable unused");
		wr(PIEL_FLAG_ADDR, 16'hFFFF);
		rd(PIEL_FLAG_ADDR, 16'h0000, "flag write one");
		pin(8'h03);
		rd(PIEL_INPUT_ADDR, 16'h0003, "lines 1..0");
		chk({8'h00, nmi_cnt}, 16'h0000, "nmi lines 1..0");
		pin(8'h83);
		chk({8'h00, nmi_cnt}, 16'h0001, "nmi rise 7");
		chk({8'h00, atn_cnt}, 16'h0001, "atn rise 7");
		rd(PIEL_FLAG_ADDR, 16'h0080, "flag 7");
		pin(8'h00);
		chk({8'h00, nmi_cnt}, 16'h0001, "nmi fall 7");
		rd(PIEL_INPUT_ADDR, 16'h0080, "locked 7");
		wr(PIEL_ENABLE_ADDR, 16'h7CFC);
		rd(PIEL_FLAG_ADDR, 16'h0080, "flag held");
		wr(PIEL_ENABLE_ADDR, 16'h7C7C);
		rd(PIEL_FLAG_ADDR, 16'h0000, "flag cleared");
		rd(PIEL_INPUT_ADDR, 16'h0000, "released 7");
		wr(PIEL_ENABLE_ADDR, 16'h0800);
		pin(8'h08);
		chk({8'h00, nmi_cnt}, 16'h0002, "nmi line 3");
		chk({8'h00, atn_cnt}, 16'h0001, "no atn line 3");
		rd(PIEL_FLAG_ADDR, 16'h0008, "flag 3");
		wr(PIEL_ENABLE_ADDR, 16'h0000);
		rd(PIEL_FLAG_ADDR, 16'h0000, "flag 3 cleared");
		wr(PIEL_INPUT_ADDR, 16'hC200);
		pin(8'h0C);
		chk({15'h0000, lcl}, 16'h0001, "local request");
		chk({15'h0000, upd}, 16'h0001, "update enable");
		chk({8'h00, atn_cnt}, 16'h0001, "no atn line 2");
		pin(8'h04);
		chk({8'h00, atn_cnt}, 16'h0002, "atn armed 3");
		chk({8'h00, nmi_cnt}, 16'h0002, "no nmi armed 3");
		rd(PIEL_FLAG_ADDR, 16'h0008, "flag armed 3");
		wr(PIEL_ENABLE_ADDR, 16'hFCFC);
		// Mid-run reset with all enables, the input 3 arm bit and a flag set
		@(negedge ref_clk_i);
		rstn_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		rd(PIEL_ENABLE_ADDR, 16'h0000, "enable mid reset");
		rd(PIEL_FLAG_ADDR, 16'h0000, "flag mid reset");
		rd(PIEL_INPUT_ADDR, 16'h0004, "input mid reset");
		chk({15'h0000, lcl}, 16'h0000, "local request off");
		chk({8'h00, nmi_cnt}, 16'h0000, "no nmi after reset");
		chk({8'h00, atn_cnt}, 16'h0000, "no atn after reset");
		conclude();
	end
endmodule // piel_top_tb
